/* File: design/dmactl_pkg.sv */
// constants, types and helpers of the dma channel transfer control block
// Contract
// - source-hold set keeps the source address fixed for the whole transfer.
// - bandwidth select picks one of twelve block sizes before bus release.
// - entering 15 bytes of a block multiple drops the bus request once.
// - bandwidth select zero holds the request until count reaches zero.
// - starting count equal to block size moves data before any release.
// - polarity bit 1 chooses level or edge sensitive external request.
// - request, or latched edge, passes two flip-flops before use.
// - acknowledge length follows the static memory wait-state count.
// - edge chosen by polarity bit 0 is latched and sets pending flag.
// - edges ignored while pending; service start clears and rearms.
// - status write clears pending and the request is discarded.
// - latch cycle 1, pending cycle 3, service cycle 4, latch reset.
// - access size from address bits 3:0 and remaining count.
// - bytes to word alignment, words to quad alignment, then quads.
// - source alignment decides access size for memory copies.
// - bursts only start at addresses with low four bits zero.
// - any byte start address and any byte count are accepted.
// - each hardware request makes one access of peripheral width.
// - narrow memory splitting is left to the memory controller.
// - one base address and one byte count form each of the two descriptors.
// - nonzero other count rolls over; peripheral modes await a request.
// - a wait counter after each peripheral access masks the request.
package dmactl_pkg;
  localparam logic [1:0]  SZ_BYTE    = 2'h0;
  localparam logic [1:0]  SZ_HALF    = 2'h1;
  localparam logic [1:0]  SZ_WORD    = 2'h2;
  localparam logic [1:0]  SZ_QUAD    = 2'h3;
  localparam logic [15:0] QUAD_BYTES = 16'h0010;
  localparam logic [15:0] WORD_BYTES = 16'h0004;
  localparam logic [16:0] BW_WINDOW  = 17'h0_000F;
  localparam logic [16:0] BW_BASE    = 17'h0_0010;
  localparam logic [3:0]  BW_MAX_SEL = 4'hC;
  localparam logic [1:0]  QUAD_BEATS = 2'h3;
  localparam int          POL_EDGE   = 1;
  localparam int          POL_RISE   = 0;
  localparam logic [31:0] RST_ADDR   = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT  = 16'h0000;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'b000_0001,
    ST_WAITREQ = 7'b000_0010,
    ST_REQ     = 7'b000_0100,
    ST_XFER    = 7'b000_1000,
    ST_RELEASE = 7'b001_0000,
    ST_ACK     = 7'b010_0000,
    ST_MASK    = 7'b100_0000
  } dmactl_state_e;

  // bandwidth block size in bytes; zero means never release
  function automatic logic [16:0] dmactl_bw_block(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > BW_MAX_SEL) ? BW_MAX_SEL : sel;
    if (s == 4'h0)
      return 17'h0_0000;
    return BW_BASE << (s - 4'h1);
  endfunction

  function automatic logic dmactl_in_window(input logic [15:0] cnt,
                                            input logic [16:0] blk);
    logic [16:0] m;
    m = ({1'b0, cnt} & (blk - 17'h0_0001));
    return m <= BW_WINDOW;
  endfunction

  function automatic logic [1:0] dmactl_pick_size(input logic [3:0]  a,
                                                  input logic [15:0] cnt);
    if (a == 4'h0 && cnt >= QUAD_BYTES)
      return SZ_QUAD;
    if (a[1:0] == 2'h0 && cnt >= WORD_BYTES)
      return SZ_WORD;
    return SZ_BYTE;
  endfunction

  // bytes moved by one beat of the given size
  function automatic logic [15:0] dmactl_step(input logic [1:0] sz);
    unique case (sz)
      SZ_BYTE: return 16'h0001;
      SZ_HALF: return 16'h0002;
      default: return 16'h0004;
    endcase
  endfunction
endpackage

/* File: design/dmactl_stream_if.sv */
// valid/ready carrier for read data with its access size
`timescale 1ns/1ns
interface dmactl_stream_if;
  logic        valid;
  logic        ready;
  logic [33:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: design/dmactl_buf2.sv */
// two-entry buffer between the bus read side and the data receiver
`timescale 1ns/1ns
module dmactl_buf2 (
  input wire logic         clk,
  input wire logic         rst,
  dmactl_stream_if.snk     in_s,
  dmactl_stream_if.src     out_s
);
  logic        hv_q;
  logic        tv_q;
  logic [33:0] head_q;
  logic [33:0] tail_q;
  logic        push;
  logic        pop;

  // ready and valid come straight from flags so no path runs through
  assign in_s.ready  = ~tv_q;
  assign out_s.valid = hv_q;
  assign out_s.data  = head_q;
  assign push = in_s.valid & ~tv_q;
  assign pop  = hv_q & out_s.ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hv_q <= 1'b0;
      tv_q <= 1'b0;
    end else begin
      unique case ({push, pop})
        2'b10: begin
          hv_q <= 1'b1;
          tv_q <= hv_q;
        end
        2'b01: begin
          hv_q <= tv_q;
          tv_q <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      head_q <= 34'h0_0000_0000;
      tail_q <= 34'h0_0000_0000;
    end else begin
      if (push && (!hv_q || (pop && !tv_q)))
        head_q <= in_s.data;
      else if (pop)
        head_q <= tail_q;
      if (push && hv_q && !(pop && !tv_q))
        tail_q <= in_s.data;
    end
  end
endmodule

/* File: design/dmactl_top.sv */
// dma channel transfer engine: sizing, bandwidth release, external requests
`timescale 1ns/1ns
module dmactl_top
  import dmactl_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        START,
  input  wire logic        HW_MODE,
  input  wire logic        SOURCE_HOLD_BIT,
  input  wire logic [3:0]  BANDWIDTH_BLOCK_SEL,
  input  wire logic [1:0]  REQUEST_POLARITY_SEL,
  input  wire logic [1:0]  PERIPH_WIDTH_SEL,
  input  wire logic [3:0]  SMC_WAIT_STATES,
  input  wire logic        STATUS_WR,
  input  wire logic        DESC_WR,
  input  wire logic        DESC_SEL,
  input  wire logic [31:0] DESC_BASE,
  input  wire logic [15:0] DESC_COUNT,
  input  wire logic        EXT_TRANSFER_REQUEST,
  input  wire logic        BUS_GRANT,
  input  wire logic        BUS_READY,
  input  wire logic [31:0] BUS_RDATA,
  input  wire logic        OUT_READY,
  output logic             BUS_REQ,
  output logic             BUS_TRANS,
  output logic [31:0]      BUS_ADDR,
  output logic [1:0]       BUS_SIZE,
  output logic             EXT_TRANSFER_ACK,
  output logic             REQUEST_PENDING_FLAG,
  output logic             NEXT_BUFFER_FREE_IRQ,
  output logic             TRANSFER_DONE,
  output logic             ACTIVE_BUFFER,
  output logic [15:0]      REMAINING_BYTE_COUNT,
  output logic             OUT_VALID,
  output logic [33:0]      OUT_DATA
);
  dmactl_stream_if rd_s ();
  dmactl_stream_if wr_s ();

  dmactl_state_e st_q;
  dmactl_state_e st_d;
  logic [31:0]   addr_q;
  logic [15:0]   cnt_q;
  logic [1:0]    size_q;
  logic [1:0]    beats_q;
  logic          act_q;
  logic [31:0]   dbase_q [2];
  logic [15:0]   dcnt_q [2];
  logic [3:0]    wait_q;
  logic          nfb_q;
  logic          done_q;
  logic          req_prev_q;
  logic          latch_q;
  logic          sync1_q;
  logic          sync2_q;
  logic          lvl1_q;
  logic          lvl2_q;
  logic          edge_mode;
  logic          edge_seen;
  logic          latch_set;
  logic          svc_start;
  logic          req_ok;
  logic          beat_done;
  logic          last_beat;
  logic [15:0]   step;
  logic [15:0]   cnt_next;
  logic [16:0]   blk;
  logic          bw_hit;
  logic          bw_enter;
  logic          bw_flag_q;
  logic          roll;
  logic          load_en;
  logic          load_sel;

  dmactl_buf2 u_buf (
    .clk   (CLK),
    .rst   (RST),
    .in_s  (rd_s.snk),
    .out_s (wr_s.src)
  );

  assign rd_s.valid = beat_done;
  assign rd_s.data  = {size_q, BUS_RDATA};
  assign wr_s.ready = OUT_READY;
  assign OUT_VALID  = wr_s.valid;
  assign OUT_DATA   = wr_s.data;

  // external request front end
  assign edge_mode = REQUEST_POLARITY_SEL[POL_EDGE];
  assign edge_seen = REQUEST_POLARITY_SEL[POL_RISE] ?
                     (EXT_TRANSFER_REQUEST & ~req_prev_q) :
                     (~EXT_TRANSFER_REQUEST & req_prev_q);
  assign latch_set = edge_mode & edge_seen & ~latch_q & ~sync2_q;
  assign svc_start = (st_q == ST_WAITREQ) && req_ok;
  // level mode relies on the peripheral dropping its line during ack
  assign req_ok    = edge_mode ? sync2_q : lvl2_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      req_prev_q <= 1'b0;
    else
      req_prev_q <= EXT_TRANSFER_REQUEST;
  end

  // a new edge wins over a service start or a software clear
  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      latch_q <= 1'b0;
    else if (latch_set)
      latch_q <= 1'b1;
    else if (svc_start || STATUS_WR)
      latch_q <= 1'b0;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else if (STATUS_WR && !latch_set) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= edge_mode & (latch_q | latch_set);
      sync2_q <= sync1_q;
    end
  end

  // level path has its own pair so the pending flag is a plain flop
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lvl1_q <= 1'b0;
      lvl2_q <= 1'b0;
    end else begin
      lvl1_q <= EXT_TRANSFER_REQUEST;
      lvl2_q <= lvl1_q;
    end
  end

  assign REQUEST_PENDING_FLAG = sync2_q;

  // beat accounting and sizing
  assign beat_done = (st_q == ST_XFER) && BUS_GRANT && BUS_READY &&
                     rd_s.ready;
  assign last_beat = beats_q == 2'h0;
  assign step      = dmactl_step(size_q);
  assign cnt_next  = (cnt_q > step) ? (cnt_q - step) : RST_COUNT;
  assign blk       = dmactl_bw_block(BANDWIDTH_BLOCK_SEL);
  // release only on entry to the window, so a count starting on a block
  // multiple moves data first
  assign bw_enter  = (blk != 17'h0_0000) && dmactl_in_window(cnt_next, blk) &&
                     !dmactl_in_window(cnt_q, blk);
  assign bw_hit    = (blk != 17'h0_0000) && (bw_enter || bw_flag_q);

  // an inner beat of a burst can enter the window; keep it until the
  // burst ends, else the release would be lost
  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      bw_flag_q <= 1'b0;
    else if (load_en || (beat_done && last_beat))
      bw_flag_q <= 1'b0;
    else if (beat_done && bw_enter)
      bw_flag_q <= 1'b1;
  end
  assign roll      = dcnt_q[~act_q] != RST_COUNT;
  assign load_en   = ((st_q == ST_IDLE) && START) ||
                     (beat_done && last_beat && cnt_next == RST_COUNT && roll);
  assign load_sel  = (st_q == ST_IDLE) ?
                     (dcnt_q[1'b0] == RST_COUNT) : ~act_q;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE:    if (START) st_d = HW_MODE ? ST_WAITREQ : ST_REQ;
      ST_WAITREQ: if (req_ok) st_d = ST_REQ;
      ST_REQ:     if (BUS_GRANT) st_d = ST_XFER;
      ST_XFER: begin
        if (beat_done && last_beat) begin
          if (HW_MODE)
            st_d = ST_ACK;
          else if (cnt_next == RST_COUNT)
            st_d = roll ? ST_REQ : ST_IDLE;
          else
            st_d = bw_hit ? ST_RELEASE : ST_REQ;
        end
      end
      ST_RELEASE: st_d = ST_REQ;
      ST_ACK:     if (wait_q == SMC_WAIT_STATES) st_d = ST_MASK;
      ST_MASK: begin
        if (wait_q == SMC_WAIT_STATES)
          st_d = (cnt_q == RST_COUNT) ? ST_IDLE : ST_WAITREQ;
      end
      default:    st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      st_q <= ST_IDLE;
    else
      st_q <= st_d;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      wait_q <= 4'h0;
    else if (st_q != st_d || (st_q != ST_ACK && st_q != ST_MASK))
      wait_q <= 4'h0;
    else
      wait_q <= wait_q + 4'h1;
  end

  // descriptors: a software write wins over the hardware free-up
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dbase_q[0] <= RST_ADDR;
      dbase_q[1] <= RST_ADDR;
      dcnt_q[0]  <= RST_COUNT;
      dcnt_q[1]  <= RST_COUNT;
    end else begin
      if (load_en)
        dcnt_q[load_sel] <= RST_COUNT;
      if (DESC_WR) begin
        dbase_q[DESC_SEL] <= DESC_BASE;
        dcnt_q[DESC_SEL]  <= DESC_COUNT;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      addr_q <= RST_ADDR;
      cnt_q  <= RST_COUNT;
      act_q  <= 1'b0;
    end else if (load_en) begin
      addr_q <= dbase_q[load_sel];
      cnt_q  <= dcnt_q[load_sel];
      act_q  <= load_sel;
    end else if (beat_done) begin
      if (!SOURCE_HOLD_BIT)
        addr_q <= addr_q + {16'h0000, step};
      cnt_q <= cnt_next;
    end
  end

  // size chosen from the source address at grant; peripheral width in
  // hardware mode, where the memory controller splits narrow memory
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      size_q  <= SZ_BYTE;
      beats_q <= 2'h0;
    end else if (st_q == ST_REQ && BUS_GRANT) begin
      if (HW_MODE) begin
        size_q  <= (PERIPH_WIDTH_SEL == SZ_QUAD) ? SZ_WORD :
                   PERIPH_WIDTH_SEL;
        beats_q <= 2'h0;
      end else begin
        size_q  <= dmactl_pick_size(addr_q[3:0], cnt_q);
        beats_q <= (dmactl_pick_size(addr_q[3:0], cnt_q) == SZ_QUAD) ?
                   QUAD_BEATS : 2'h0;
      end
    end else if (beat_done && !last_beat) begin
      beats_q <= beats_q - 2'h1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      nfb_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      nfb_q  <= load_en && st_q == ST_XFER;
      done_q <= (st_q != ST_IDLE) && (st_d == ST_IDLE);
    end
  end

  // bus outputs registered from next state
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      BUS_REQ          <= 1'b0;
      BUS_TRANS        <= 1'b0;
      EXT_TRANSFER_ACK <= 1'b0;
    end else begin
      BUS_REQ          <= st_d == ST_REQ || st_d == ST_XFER;
      BUS_TRANS        <= st_d == ST_XFER;
      EXT_TRANSFER_ACK <= st_d == ST_ACK;
    end
  end

  assign BUS_ADDR             = addr_q;
  assign BUS_SIZE             = size_q;
  assign NEXT_BUFFER_FREE_IRQ = nfb_q;
  assign TRANSFER_DONE        = done_q;
  assign ACTIVE_BUFFER        = act_q;
  assign REMAINING_BYTE_COUNT = cnt_q;

  hold_src_a: assert property (@(posedge CLK) disable iff (RST)
    (beat_done && SOURCE_HOLD_BIT && !load_en) |=> addr_q == $past(addr_q))
    else $error("source address moved under hold");
  bw_zero_a: assert property (@(posedge CLK) disable iff (RST)
    (st_q == ST_RELEASE) |-> $past(blk) != 17'h0_0000)
    else $error("release with bandwidth select zero");
  release_back_a: assert property (@(posedge CLK) disable iff (RST)
    (st_q == ST_RELEASE) |-> !BUS_REQ ##1 BUS_REQ)
    else $error("request not dropped then restored");
  ack_len_a: assert property (@(posedge CLK) disable iff (RST)
    (st_q == ST_ACK) |-> wait_q <= SMC_WAIT_STATES)
    else $error("acknowledge longer than wait states");
  pend_time_a: assert property (@(posedge CLK) disable iff (RST)
    (latch_set && !STATUS_WR) ##1 !STATUS_WR |=> REQUEST_PENDING_FLAG)
    else $error("pending not shown two cycles after edge");
  latch_clr_a: assert property (@(posedge CLK) disable iff (RST)
    (svc_start && edge_mode && !latch_set) |=> !latch_q ##2 !sync2_q || latch_q)
    else $error("latch not reset at service start");
  quad_align_a: assert property (@(posedge CLK) disable iff (RST)
    (st_q == ST_REQ && BUS_GRANT && !HW_MODE && addr_q[3:0] != 4'h0)
    |=> size_q != SZ_QUAD)
    else $error("burst from unaligned address");
  hw_width_a: assert property (@(posedge CLK) disable iff (RST)
    (BUS_TRANS && HW_MODE) |-> beats_q == 2'h0 && size_q != SZ_QUAD)
    else $error("hardware access not single peripheral width");
  mask_a: assert property (@(posedge CLK) disable iff (RST)
    (st_q == ST_MASK) |-> !BUS_REQ && !svc_start)
    else $error("request served during mask count");
endmodule

/* File: bench/dmactl_far_model.sv */
// far-side model: bus arbiter, reading memory and request peripheral
`timescale 1ns/1ns
module dmactl_far_model #(
  parameter logic [31:0] DATA_KEY = 32'h5A5A_0000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        bus_req,
  input  wire logic        bus_trans,
  input  wire logic [31:0] bus_addr,
  input  wire logic        ack,
  input  wire logic        slow,
  input  wire logic        lvl_want,
  input  wire logic        edge_line,
  output logic             bus_grant,
  output logic             bus_ready,
  output logic [31:0]      bus_rdata,
  output logic             ext_req
);
  logic        gnt_q;
  logic        tog_q;
  logic        lvl_q;
  logic [31:0] junk_q;
  // grant lags the request by one cycle, as a shared arbiter would
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gnt_q  <= 1'h0;
      tog_q  <= 1'h0;
      junk_q <= 32'h0000_0000;
    end else begin
      gnt_q  <= bus_req;
      tog_q  <= ~tog_q;
      junk_q <= junk_q + 32'h1357_9BDF;
    end
  end
  // level peripheral keeps asking until it is acknowledged
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      lvl_q <= 1'h0;
    else if (ack)
      lvl_q <= 1'h0;
    else if (lvl_want)
      lvl_q <= 1'h1;
  end
  assign bus_grant = gnt_q;
  assign bus_ready = slow ? tog_q : 1'h1;
  // off-transfer data changes every cycle so a stale word never passes
  assign bus_rdata = bus_trans ? (bus_addr ^ DATA_KEY) : junk_q;
  assign ext_req   = (lvl_q & ~ack) | edge_line;
endmodule

/* File: bench/tb_top.sv */
// self-checking bench of the dma channel transfer control block
`timescale 1ns/1ns
module tb_top
  import dmactl_pkg::*;
;
  localparam logic [31:0] DATA_KEY = 32'h5A5A_0000;
  localparam int          LIMIT    = 20000;
  logic        CLK, RST, START, HW_MODE, SOURCE_HOLD_BIT, STATUS_WR;
  logic        DESC_WR, DESC_SEL, OUT_READY, slow, lvl_want, edge_line;
  logic [3:0]  BANDWIDTH_BLOCK_SEL, SMC_WAIT_STATES;
  logic [1:0]  REQUEST_POLARITY_SEL, PERIPH_WIDTH_SEL;
  logic [31:0] DESC_BASE, BUS_RDATA, BUS_ADDR;
  logic [15:0] DESC_COUNT, REMAINING_BYTE_COUNT;
  logic        EXT_TRANSFER_REQUEST, BUS_GRANT, BUS_READY, BUS_REQ;
  logic        BUS_TRANS, EXT_TRANSFER_ACK, REQUEST_PENDING_FLAG;
  logic        NEXT_BUFFER_FREE_IRQ, TRANSFER_DONE, ACTIVE_BUFFER;
  logic        OUT_VALID, req_prev;
  logic [1:0]  BUS_SIZE;
  logic [33:0] OUT_DATA;
  logic [33:0] got_q[$];
  logic [33:0] exp_q[$];
  int          errors, checks_done, rises, acks, irqs, cycles;

  dmactl_top dmactl_top_inst (
    .CLK(CLK), .RST(RST), .START(START), .HW_MODE(HW_MODE),
    .SOURCE_HOLD_BIT(SOURCE_HOLD_BIT),
    .BANDWIDTH_BLOCK_SEL(BANDWIDTH_BLOCK_SEL),
    .REQUEST_POLARITY_SEL(REQUEST_POLARITY_SEL),
    .PERIPH_WIDTH_SEL(PERIPH_WIDTH_SEL), .SMC_WAIT_STATES(SMC_WAIT_STATES),
    .STATUS_WR(STATUS_WR), .DESC_WR(DESC_WR), .DESC_SEL(DESC_SEL),
    .DESC_BASE(DESC_BASE), .DESC_COUNT(DESC_COUNT),
    .EXT_TRANSFER_REQUEST(EXT_TRANSFER_REQUEST), .BUS_GRANT(BUS_GRANT),
    .BUS_READY(BUS_READY), .BUS_RDATA(BUS_RDATA), .OUT_READY(OUT_READY),
    .BUS_REQ(BUS_REQ), .BUS_TRANS(BUS_TRANS), .BUS_ADDR(BUS_ADDR),
    .BUS_SIZE(BUS_SIZE), .EXT_TRANSFER_ACK(EXT_TRANSFER_ACK),
    .REQUEST_PENDING_FLAG(REQUEST_PENDING_FLAG),
    .NEXT_BUFFER_FREE_IRQ(NEXT_BUFFER_FREE_IRQ),
    .TRANSFER_DONE(TRANSFER_DONE), .ACTIVE_BUFFER(ACTIVE_BUFFER),
    .REMAINING_BYTE_COUNT(REMAINING_BYTE_COUNT), .OUT_VALID(OUT_VALID),
    .OUT_DATA(OUT_DATA));

  dmactl_far_model #(.DATA_KEY(DATA_KEY)) dmactl_far_model_inst (
    .clk(CLK), .rst(RST), .bus_req(BUS_REQ), .bus_trans(BUS_TRANS),
    .bus_addr(BUS_ADDR), .ack(EXT_TRANSFER_ACK), .slow(slow),
    .lvl_want(lvl_want), .edge_line(edge_line), .bus_grant(BUS_GRANT),
    .bus_ready(BUS_READY), .bus_rdata(BUS_RDATA),
    .ext_req(EXT_TRANSFER_REQUEST));

  initial begin
    CLK = 1'h0;
    forever #2 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cycles <= cycles + 1;
    req_prev <= BUS_REQ;
    if (BUS_REQ && !req_prev)
      rises <= rises + 1;
    if (EXT_TRANSFER_ACK)
      acks <= acks + 1;
    if (NEXT_BUFFER_FREE_IRQ)
      irqs <= irqs + 1;
    if (OUT_VALID && OUT_READY)
      got_q.push_back(OUT_DATA);
    if (cycles == LIMIT) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [33:0] seen,
                       input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge CLK);
  endtask

  task automatic want(input logic [1:0] sz, input logic [31:0] a);
    exp_q.push_back({sz, a ^ DATA_KEY});
  endtask

  // reference walk: bytes to word, words to quad, then quad bursts
  task automatic expect_sw(input logic [31:0] a, input int n,
                           input logic hold);
    logic [31:0] p;
    int          k;
    p = a;
    while (n > 0) begin
      k = (p[3:0] == 4'h0 && n >= 16) ? 4 : 1;
      repeat (k) begin
        want((k == 4) ? SZ_QUAD : (p[1:0] == 2'h0 && n >= 4) ? SZ_WORD
             : SZ_BYTE, p);
        n = n - ((k == 4 || (p[1:0] == 2'h0 && n >= 4)) ? 4 : 1);
        if (!hold)
          p = p + ((exp_q[$][33:32] == SZ_BYTE) ? 1 : 4);
      end
    end
  endtask

  task automatic load(input logic sel, input logic [31:0] a,
                      input logic [15:0] n);
    @(negedge CLK);
    DESC_WR = 1'h1;
    DESC_SEL = sel;
    DESC_BASE = a;
    DESC_COUNT = n;
    @(negedge CLK);
    DESC_WR = 1'h0;
  endtask

  task automatic go();
    got_q.delete();
    rises = 0;
    acks = 0;
    irqs = 0;
    START = 1'h1;
    tick(1);
    START = 1'h0;
  endtask

  task automatic sw(input logic [31:0] a, input logic [15:0] n,
                    input logic hold, input logic [3:0] bw);
    expect_sw(a, int'(n), hold);
    HW_MODE = 1'h0;
    SOURCE_HOLD_BIT = hold;
    BANDWIDTH_BLOCK_SEL = bw;
    load(1'h0, a, n);
    go();
  endtask

  task automatic hw(input logic [1:0] pol, input logic [1:0] pw,
                    input logic [3:0] ws, input logic [31:0] a,
                    input logic [15:0] n);
    HW_MODE = 1'h1;
    SOURCE_HOLD_BIT = 1'h0;
    REQUEST_POLARITY_SEL = pol;
    PERIPH_WIDTH_SEL = pw;
    SMC_WAIT_STATES = ws;
    load(1'h0, a, n);
    go();
  endtask

  task automatic finish_run(input string what);
    logic seen;
    int   i;
    seen = 1'h0;
    for (i = 0; i < 400 && !seen; i++) begin
      @(negedge CLK);
      seen = (TRANSFER_DONE === 1'h1);
    end
    check(what, {33'h0, seen}, 34'h1);
    tick(4);
    check("words", 34'(got_q.size()), 34'(exp_q.size()));
    foreach (exp_q[j]) check("word", got_q[j], exp_q[j]);
    exp_q.delete();
  endtask

  task automatic t_bw();
    logic [3:0]  sel[3] = '{4'h0, 4'h2, 4'h2};
    logic [15:0] cnt[3] = '{16'h0040, 16'h0040, 16'h0020};
    int          req[3] = '{1, 2, 1};
    for (int i = 0; i < 3; i++) begin
      slow = (i == 1);
      sw(32'h0000_3000, cnt[i], 1'h0, sel[i]);
      finish_run("bandwidth run");
      check("bus requests", 34'(rises), 34'(req[i]));
    end
    slow = 1'h0;
  endtask

  task automatic t_level();
    int step;
    for (int w = 0; w < 3; w++) begin
      step = 1 << w;
      hw(2'h0, 2'(w), 4'h2, 32'h0000_7000, 16'(2 * step));
      want(2'(w), 32'h0000_7000);
      want(2'(w), 32'h0000_7000 + step);
      tick(4);
      check("idle request", 34'(BUS_REQ), 34'h0);
      lvl_want = 1'h1;
      tick(1);
      lvl_want = 1'h0;
      check("sync delay", 34'(BUS_REQ), 34'h0);
      tick(20);
      check("one access", 34'(REMAINING_BYTE_COUNT), 34'(step));
      lvl_want = 1'h1;
      tick(1);
      lvl_want = 1'h0;
      finish_run("level run");
      check("ack length", 34'(acks), 34'h6);
    end
  endtask

  task automatic t_edge();
    hw(2'h3, SZ_WORD, 4'h1, 32'h0000_8000, 16'h0008);
    want(SZ_WORD, 32'h0000_8000);
    want(SZ_WORD, 32'h0000_8004);
    tick(3);
    edge_line = 1'h1;
    tick(1);
    check("pending early", 34'(REQUEST_PENDING_FLAG), 34'h0);
    edge_line = 1'h0;
    tick(1);
    edge_line = 1'h1;
    tick(1);
    check("pending set", 34'(REQUEST_PENDING_FLAG), 34'h1);
    tick(20);
    check("edge ignored", 34'(REMAINING_BYTE_COUNT), 34'h4);
    check("pending clear", 34'(REQUEST_PENDING_FLAG), 34'h0);
    edge_line = 1'h0;
    tick(1);
    edge_line = 1'h1;
    finish_run("edge run");
    check("ack length", 34'(acks), 34'h4);
    edge_line = 1'h0;
  endtask

  task automatic t_fall();
    tick(1);
    REQUEST_POLARITY_SEL = 2'h2;
    tick(1);
    edge_line = 1'h1;
    tick(2);
    hw(2'h2, SZ_BYTE, 4'h0, 32'h0000_9000, 16'h0001);
    want(SZ_BYTE, 32'h0000_9000);
    edge_line = 1'h0;
    tick(1);
    STATUS_WR = 1'h1;
    tick(1);
    STATUS_WR = 1'h0;
    tick(10);
    check("discarded", 34'(REMAINING_BYTE_COUNT), 34'h1);
    check("flag cleared", 34'(REQUEST_PENDING_FLAG), 34'h0);
    edge_line = 1'h1;
    tick(6);
    check("rise ignored", 34'(REMAINING_BYTE_COUNT), 34'h1);
    edge_line = 1'h0;
    finish_run("fall run");
  endtask

  initial begin
    {START, HW_MODE, SOURCE_HOLD_BIT, STATUS_WR, DESC_WR, DESC_SEL} = '0;
    {slow, lvl_want, edge_line, BANDWIDTH_BLOCK_SEL, SMC_WAIT_STATES} = '0;
    {REQUEST_POLARITY_SEL, PERIPH_WIDTH_SEL, DESC_BASE, DESC_COUNT} = '0;
    {errors, checks_done, rises, acks, irqs, cycles} = '0;
    OUT_READY = 1'h1;
    RST = 1'h1;
    tick(3);
    RST = 1'h0;
    sw(32'h0000_1003, 16'h002F, 1'h0, 4'h0);
    finish_run("unaligned run");
    sw(32'h0000_2000, 16'h0028, 1'h1, 4'h0);
    finish_run("fill run");
    t_bw();
    load(1'h1, 32'h0000_5000, 16'h0008);
    sw(32'h0000_4000, 16'h0004, 1'h0, 4'h0);
    expect_sw(32'h0000_5000, 8, 1'h0);
    finish_run("rollover run");
    check("free pulses", 34'(irqs), 34'h1);
    check("active buffer", 34'(ACTIVE_BUFFER), 34'h1);
    // receiver stalls: the two-entry buffer must hold back the bus
    OUT_READY = 1'h0;
    sw(32'h0000_6000, 16'h0010, 1'h0, 4'h0);
    tick(12);
    check("stalled count", 34'(REMAINING_BYTE_COUNT), 34'h8);
    check("burst size", 34'(BUS_SIZE), 34'(SZ_QUAD));
    OUT_READY = 1'h1;
    finish_run("stall run");
    t_level();
    t_edge();
    t_fall();
    final_report();
  end
endmodule
